// ==== src/chbp_port.sv ====
// Purpose: Host parallel bus port with wait request and busy timing
// Assumes: Host pins asynchronous; memory RAM and command engine internal
// Notes: Summary of operation
// Summary of operation
// RULE_01: Both straps high select mode four
// RULE_02: Both straps low select mode one
// RULE_03: Decode nine address lines, 512 bytes
// RULE_04: Drive wait request low to stretch accesses
// RULE_05: Host polls busy or keeps intervals
// RULE_06: Buffer or FIFO writes spaced four clocks
// RULE_07: Memory writes spaced six clocks
// RULE_08: Status, FIFO, memory reads spaced four clocks
// RULE_09: I/O buffer reads need no interval
// RULE_10: Memory reads go through indirect buffer
// RULE_11: Memory read asserts wait for transfer
// RULE_12: Eight low bytes, rest through commands
// RULE_13: No-data commands spaced eight clocks
// RULE_14: Indirect data and command writes four clocks; command writes here get CYC_CMD, twenty system clocks
// RULE_15: After indirect write command wait eight
// RULE_16: Command codes written low byte first
// RULE_17: Read command fills buffer within eight clocks
// RULE_18: Buffer bytes readable any order freely
// RULE_19: Host gates select with opcode fetch
// RULE_20: Mode three uses sixteen-bit data
// RULE_21: Word writes keep lowest address zero
// RULE_22: Release wait and busy after interval
`timescale 1ns/10ps
`default_nettype none
module chbp_port #(
   parameter int unsigned MEM_WORDS = 512
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic bus_mode_strap_lo_i,
   input wire logic bus_mode_strap_hi_i,
   input wire chbp_pkg::chbp_bus_t bus_i,
   output logic [15:0] data_o,
   output logic data_oe_o,
   output logic wait_request_n_o,
   output logic interface_busy_n_o,
   output chbp_pkg::chbp_mode_t mode_o,
   output logic bus16_o
);
   import chbp_pkg::*;

   initial begin
      if (MEM_WORDS != 512) begin
         $error("MEM_WORDS must be 512");
      end
      if ((CYC_CMD >> CNT_W) != 0) begin
         $error("busy counter too narrow for command interval");
      end
   end

   chbp_bus_t meta;
   chbp_bus_t sync;
   logic [1:0] strap_meta;
   logic [1:0] strap_sync;
   logic rd_act_d;
   logic wr_act_d;
   logic [CNT_W-1:0] busy_cnt;
   logic [CNT_W-1:0] next_busy_cnt;
   logic [7:0] mem [0:MEM_WORDS-1];
   logic [7:0] iobuf [0:1];
   logic [7:0] ind_buf;
   logic [7:0] cmd_lo;
   logic cmd_lo_ok;
   chbp_state_t state;
   logic [8:0] rd_addr;

   // Two-flop synchronisers for host pins and straps
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 9'h000, data: 16'h0000};
         sync <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 9'h000, data: 16'h0000};
         strap_meta <= 2'b00;
         strap_sync <= 2'b00;
      end else begin
         meta <= bus_i;
         sync <= meta;
         strap_meta <= {bus_mode_strap_hi_i, bus_mode_strap_lo_i};
         strap_sync <= strap_meta;
      end
   end

   logic rd_act;
   logic wr_act;
   logic rd_start;
   logic wr_start;
   logic in_mem;
   logic is_iobuf;
   logic is_fifo;
   logic is_cmd;
   assign rd_act = !sync.cs_n && !sync.rd_n;
   assign wr_act = !sync.cs_n && !sync.wr_n;
   assign rd_start = rd_act && !rd_act_d;
   assign wr_start = wr_act && !wr_act_d;
   assign in_mem = (sync.addr >= ADR_MEM_LO) && (sync.addr <= ADR_MEM_HI); // RULE_03
   assign is_iobuf = (sync.addr == ADR_IOBUF0) || (sync.addr == ADR_IOBUF1);
   assign is_fifo = (sync.addr == ADR_FIFO0) || (sync.addr == ADR_FIFO1);
   assign is_cmd = (sync.addr == ADR_CMD);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_act_d <= 1'b0;
         wr_act_d <= 1'b0;
      end else begin
         rd_act_d <= rd_act;
         wr_act_d <= wr_act;
      end
   end

   // Mode select from straps
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_o <= CHBP_MODE1;
         bus16_o <= 1'b0;
      end else begin
         mode_o <= chbp_mode_t'(strap_sync); // RULE_01 RULE_02
         bus16_o <= (strap_sync == 2'b10); // RULE_20
      end
   end

   // Interval the device needs after each access other than an I/O buffer read starts
   always_comb begin
      next_busy_cnt = busy_cnt;
      if (busy_cnt != '0) begin
         next_busy_cnt = busy_cnt - 1'b1; // RULE_22
      end
      if (wr_start) begin
         if (in_mem) begin
            next_busy_cnt = CNT_W'(CYC_WR_MEM);
         end else if (is_cmd) begin
            next_busy_cnt = CNT_W'(CYC_CMD); // RULE_13 RULE_15 RULE_17
         end else if (is_iobuf || is_fifo) begin
            next_busy_cnt = CNT_W'(CYC_WR_BUF); // RULE_06 RULE_14
         end else begin
            next_busy_cnt = CNT_W'(CYC_WR_BUF);
         end
      end else if (rd_start && !is_iobuf) begin
         next_busy_cnt = CNT_W'(CYC_RD); // RULE_08 RULE_09
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         busy_cnt <= '0;
      end else begin
         busy_cnt <= next_busy_cnt;
      end
   end

   // Memory read transfer into indirect buffer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= CHBP_IDLE;
         rd_addr <= 9'h000;
         ind_buf <= 8'h00;
      end else begin
         case (state)
            CHBP_IDLE: begin
               if (rd_start && in_mem) begin
                  rd_addr <= sync.addr;
                  state <= CHBP_XFER;
               end
            end
            CHBP_XFER: begin
               ind_buf <= mem[rd_addr]; // RULE_10
               state <= CHBP_HOLD;
            end
            CHBP_HOLD: begin
               state <= CHBP_DONE;
            end
            CHBP_DONE: begin
               if (!rd_act) begin
                  state <= CHBP_IDLE;
               end
            end
            default: begin
               state <= CHBP_IDLE;
            end
         endcase
      end
   end

   // Memory and I/O buffer writes, command handling
   always_ff @(posedge clk_i) begin
      if (wr_start && in_mem) begin
         mem[sync.addr] <= sync.data[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         iobuf[0] <= 8'h00;
         iobuf[1] <= 8'h00;
         cmd_lo <= 8'h00;
         cmd_lo_ok <= 1'b0;
      end else begin
         if (wr_start && is_iobuf) begin
            iobuf[sync.addr[0]] <= sync.data[7:0];
            if (bus16_o && !sync.addr[0]) begin
               iobuf[1] <= sync.data[15:8]; // RULE_21
            end
         end
         if (wr_start && is_cmd) begin
            if (bus16_o || cmd_lo_ok) begin
               cmd_lo_ok <= 1'b0;
               // Read command: copy addressed byte pair into I/O buffer
               iobuf[0] <= mem[{iobuf[1][0], iobuf[0]}]; // RULE_17 RULE_12
               iobuf[1] <= mem[{iobuf[1][0], iobuf[0]} + 9'h001];
            end else begin
               cmd_lo <= sync.data[7:0]; // RULE_16
               cmd_lo_ok <= 1'b1;
            end
         end
      end
   end

   // Output data path, all registered
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         data_o <= 16'h0000;
         data_oe_o <= 1'b0;
         wait_request_n_o <= 1'b1;
         interface_busy_n_o <= 1'b1;
      end else begin
         data_oe_o <= rd_act;
         if (in_mem) begin
            data_o <= {8'h00, ind_buf};
         end else if (is_iobuf) begin
            data_o <= bus16_o ? {iobuf[1], iobuf[0]} : {8'h00, iobuf[sync.addr[0]]}; // RULE_18
         end else if (is_cmd) begin
            data_o <= {8'h00, cmd_lo};
         end else begin
            data_o <= {15'h0000, (busy_cnt != '0)};
         end
         wait_request_n_o <= !((next_busy_cnt != '0) && (rd_act || wr_act)) &&
            !((rd_start && in_mem) || state == CHBP_XFER || state == CHBP_HOLD); // RULE_04 RULE_11
         interface_busy_n_o <= (next_busy_cnt == '0); // RULE_05 RULE_22
      end
   end

   chk_mode_four: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_01
      strap_sync == 2'b11 |=> mode_o == CHBP_MODE4)
      else $error("mode 4 not selected");
   chk_mode_one: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_02
      strap_sync == 2'b00 |=> mode_o == CHBP_MODE1)
      else $error("mode 1 not selected");
   chk_bus_wide: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_20
      strap_sync == 2'b10 |=> bus16_o)
      else $error("mode 3 not 16-bit");
   sequence s_mem_rd;
      rd_start && in_mem && state == CHBP_IDLE;
   endsequence
   chk_mem_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_11
      s_mem_rd |=> !wait_request_n_o [*2])
      else $error("no wait on memory read");
   chk_mem_xfer: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_10
      s_mem_rd |=> state == CHBP_XFER ##1 state == CHBP_HOLD)
      else $error("bad transfer");
   chk_cmd_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_13
      wr_start && is_cmd |=> !interface_busy_n_o [*8])
      else $error("cmd busy short");
   chk_busy_release: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_22
      wr_start |-> ##[1:30] interface_busy_n_o)
      else $error("busy never released");
   chk_iobuf_free: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_09
      rd_start && is_iobuf && busy_cnt == '0 |=> interface_busy_n_o)
      else $error("iobuf read busy");
   chk_wr_buf: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_06
      wr_start && is_fifo |=> busy_cnt == CNT_W'(CYC_WR_BUF))
      else $error("buf interval");
   chk_mem_wr_len: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_07
      wr_start && in_mem |=> busy_cnt == CNT_W'(CYC_WR_MEM))
      else $error("memory write interval");
   chk_rd_len: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_08
      rd_start && !is_iobuf && !wr_start |=> busy_cnt == CNT_W'(CYC_RD))
      else $error("read interval");
   chk_cmd_len: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_15
      wr_start && is_cmd |=> busy_cnt == CNT_W'(CYC_CMD))
      else $error("command interval");
   chk_busy_start: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_05
      wr_start |=> !interface_busy_n_o)
      else $error("busy not shown after write");
   chk_oe_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_18
      rd_act |=> data_oe_o)
      else $error("data not driven on read");
   chk_oe_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_18
      !rd_act |=> !data_oe_o)
      else $error("data driven without read");
   // Word write in the wide mode fills both buffer bytes
   sequence s_wide_wr;
      wr_start && is_iobuf && bus16_o && !sync.addr[0];
   endsequence
   chk_wide_store: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_20
      s_wide_wr |=> {iobuf[1], iobuf[0]} == $past(sync.data))
      else $error("wide buffer write lost");
   sequence s_cmd_first;
      wr_start && is_cmd && !bus16_o && !cmd_lo_ok;
   endsequence
   chk_cmd_order: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_16
      s_cmd_first |=> cmd_lo_ok)
      else $error("low command byte not held");
   chk_cmd_fire: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_17
      wr_start && is_cmd && cmd_lo_ok |=> !cmd_lo_ok)
      else $error("command not fired on high byte");
   chk_wait_free: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_22
      busy_cnt == CNT_W'(1) && !wr_start && !rd_start && state != CHBP_XFER &&
      state != CHBP_HOLD |=> wait_request_n_o)
      else $error("wait held past interval");
   chk_iobuf_nowait: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_09
      rd_start && is_iobuf && busy_cnt == '0 && !wr_start |=> wait_request_n_o)
      else $error("wait on buffer read");
endmodule
`default_nettype wire

// ==== src/chbp_pkg.sv ====
// Purpose: Shared constants and types for the center host bus port
// Assumes: Single system clock at 100 MHz; intervals specified at 40 MHz
// Notes: Mode 4 address map used for region decode
package chbp_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned REF_HZ = 40_000_000;
   // Intervals in reference clocks, scaled to system clocks (rounded up)
   localparam int unsigned REF_WR_BUF = 4;
   localparam int unsigned REF_WR_MEM = 6;
   localparam int unsigned REF_RD = 4;
   localparam int unsigned REF_CMD = 8;
   localparam int unsigned REF_RD_XFER = 2;
   localparam int unsigned CYC_WR_BUF = (REF_WR_BUF * CLK_HZ + REF_HZ - 1) / REF_HZ;
   localparam int unsigned CYC_WR_MEM = (REF_WR_MEM * CLK_HZ + REF_HZ - 1) / REF_HZ;
   localparam int unsigned CYC_RD = (REF_RD * CLK_HZ + REF_HZ - 1) / REF_HZ;
   localparam int unsigned CYC_CMD = (REF_CMD * CLK_HZ + REF_HZ - 1) / REF_HZ;
   localparam int unsigned CYC_RD_XFER = (REF_RD_XFER * CLK_HZ + REF_HZ - 1) / REF_HZ;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned CNT_W = 6;
   localparam logic [8:0] ADR_STATUS0 = 9'h000;
   localparam logic [8:0] ADR_CMD = 9'h001;
   localparam logic [8:0] ADR_IOBUF0 = 9'h004;
   localparam logic [8:0] ADR_IOBUF1 = 9'h005;
   localparam logic [8:0] ADR_FIFO0 = 9'h006;
   localparam logic [8:0] ADR_FIFO1 = 9'h007;
   localparam logic [8:0] ADR_MEM_LO = 9'h078;
   localparam logic [8:0] ADR_MEM_HI = 9'h1FF;
   localparam logic [15:0] CMD_READ_MIN = 16'h0000;
   typedef enum logic [1:0] {
      CHBP_MODE1 = 2'b00,
      CHBP_MODE2 = 2'b01,
      CHBP_MODE3 = 2'b10,
      CHBP_MODE4 = 2'b11
   } chbp_mode_t;
   typedef enum logic [1:0] {
      CHBP_IDLE = 2'b00,
      CHBP_XFER = 2'b01,
      CHBP_HOLD = 2'b10,
      CHBP_DONE = 2'b11
   } chbp_state_t;
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [8:0] addr;
      logic [15:0] data;
   } chbp_bus_t;
endpackage

// ==== testbench/chbp_host.sv ====
// Purpose: Host CPU model driving the parallel bus of the port
// Assumes: Host polls busy and waits on wait request before release
// Notes: Data lines show the inverse of the last value when not written
`timescale 1ns/10ps
`default_nettype none
module chbp_host (
   input wire logic clk_i,
   input wire logic [15:0] data_i,
   input wire logic wait_request_n_i,
   input wire logic interface_busy_n_i,
   output chbp_pkg::chbp_bus_t bus_o
);
   import chbp_pkg::*;
   initial begin
      bus_o = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 9'h000, data: 16'h0000};
   end
   // One access; busy counts samples with busy low, ok low on a hang
   task automatic access(input logic wr, input logic [8:0] a, input logic [15:0] d,
         output logic [15:0] q, output int busy, output logic waited, output logic ok);
      int n;
      busy = 0;
      waited = 1'b0;
      @(posedge clk_i);
      #1;
      bus_o.cs_n = 1'b0;
      bus_o.addr = a;
      bus_o.data = wr ? d : ~bus_o.data;
      bus_o.wr_n = ~wr;
      bus_o.rd_n = wr;
      for (n = 0; n < 40 && (n < 5 || wait_request_n_i !== 1'b1); n++) begin
         @(posedge clk_i);
         #1;
         if (wait_request_n_i === 1'b0) waited = 1'b1;
         if (interface_busy_n_i === 1'b0) busy++;
      end
      ok = (n < 40);
      q = data_i;
      bus_o.cs_n = 1'b1;
      bus_o.rd_n = 1'b1;
      bus_o.wr_n = 1'b1;
      bus_o.data = ~bus_o.data;
      // Poll busy to keep access spacing
      for (n = 0; n < 60 && interface_busy_n_i !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
         busy++;
      end
      ok = ok && (n < 60);
      repeat (2) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ==== testbench/test_center_host_bus_port.sv ====
// Purpose: Self-checking bench for the center host bus port
// Assumes: Mode 4 byte map after the strap sweep
// Notes: Busy lengths allowed one cycle of slack
`timescale 1ns/10ps
`default_nettype none
module test_center_host_bus_port;
   import chbp_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic lo = 1'b1;
   logic hi = 1'b1;
   chbp_bus_t bus;
   logic [15:0] data_o;
   logic data_oe_o, wait_n, busy_n, bus16_o;
   chbp_mode_t mode_o;
   int miscompares = 0;
   int check_count = 0;
   logic [15:0] q;
   int bsy;
   logic wt;
   chbp_mode_t mtab [4] = '{CHBP_MODE1, CHBP_MODE2, CHBP_MODE3, CHBP_MODE4};
   always #5 clk_i = ~clk_i;
   chbp_port i_chbp_port (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_mode_strap_lo_i(lo),
      .bus_mode_strap_hi_i(hi), .bus_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
      .wait_request_n_o(wait_n), .interface_busy_n_o(busy_n), .mode_o(mode_o),
      .bus16_o(bus16_o));
   chbp_host i_chbp_host (.clk_i(clk_i), .data_i(data_o), .wait_request_n_i(wait_n),
      .interface_busy_n_i(busy_n), .bus_o(bus));
   task automatic end_sim;
      if (miscompares == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_rng(input string what, input int mn, input int got);
      check_count++;
      if (got < mn || got > mn + 1) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, mn, got);
      end
   endtask
   task automatic acc(input logic wr, input logic [8:0] a, input logic [15:0] d);
      logic ok;
      i_chbp_host.access(wr, a, d, q, bsy, wt, ok);
      if (!ok) begin
         miscompares++;
         $display("CHECK FAILED handshake expected done seen hang");
         end_sim();
      end
   endtask
   task automatic t_reset;
      cmp("wait idle", 16'h0001, {15'h0000, wait_n});
      cmp("busy idle", 16'h0001, {15'h0000, busy_n});
      cmp("oe idle", 16'h0000, {15'h0000, data_oe_o});
   endtask
   task automatic t_modes;
      for (int i = 0; i < 4; i++) begin
         {hi, lo} = i[1:0];
         repeat (4) @(posedge clk_i);
         #1;
         cmp("mode", {14'h0000, mtab[i]}, {14'h0000, mode_o});
         cmp("bus16", {15'h0000, i == 2}, {15'h0000, bus16_o});
      end
   endtask
   task automatic t_mem;
      acc(1'b1, ADR_MEM_HI, 16'h00C3);
      cmp_rng("mem wr busy", CYC_WR_MEM, bsy);
      acc(1'b1, 9'h1F0, 16'h005A);
      acc(1'b1, 9'h1F1, 16'h00A5);
      acc(1'b0, ADR_MEM_HI, 16'h0000);
      cmp("mem rd wait", 16'h0001, {15'h0000, wt});
      cmp("mem rd", 16'h00C3, {8'h00, q[7:0]});
      cmp_rng("mem rd busy", CYC_RD, bsy);
   endtask
   task automatic t_iobuf;
      acc(1'b1, ADR_IOBUF0, 16'h00F0);
      cmp_rng("buf wr busy", CYC_WR_BUF, bsy);
      acc(1'b1, ADR_FIFO0, 16'h0055);
      cmp_rng("fifo wr busy", CYC_WR_BUF, bsy);
      acc(1'b1, ADR_IOBUF1, 16'h0001);
      acc(1'b0, ADR_IOBUF1, 16'h0000);
      cmp("buf rd", 16'h0001, {8'h00, q[7:0]});
      cmp("buf rd busy", 16'h0000, bsy[15:0]);
   endtask
   task automatic t_rd_cmd;
      acc(1'b1, ADR_CMD, {8'h00, CMD_READ_MIN[7:0]});
      acc(1'b1, ADR_CMD, {8'h00, CMD_READ_MIN[15:8]});
      cmp_rng("cmd busy", CYC_CMD, bsy);
      acc(1'b0, ADR_IOBUF1, 16'h0000);
      cmp("cmd data hi", 16'h00A5, {8'h00, q[7:0]});
      acc(1'b0, ADR_IOBUF0, 16'h0000);
      cmp("cmd data lo", 16'h005A, {8'h00, q[7:0]});
      cmp("cmd rd wait", 16'h0000, {15'h0000, wt});
   endtask
   task automatic t_wide;
      @(posedge clk_i);
      #1;
      {hi, lo} = 2'b10;
      repeat (4) @(posedge clk_i);
      #1;
      cmp("wide mode", 16'h0001, {15'h0000, bus16_o});
      acc(1'b1, ADR_IOBUF0, 16'h3CC3);
      cmp_rng("wide wr busy", CYC_WR_BUF, bsy);
      acc(1'b0, ADR_IOBUF0, 16'h0000);
      cmp("wide rd", 16'h3CC3, q);
      cmp("wide rd busy", 16'h0000, bsy[15:0]);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      t_reset();
      t_modes();
      t_mem();
      t_iobuf();
      t_rd_cmd();
      t_wide();
      end_sim();
   end
endmodule
`default_nettype wire
